// ===== atr_pkg.sv
// Package for the converter trigger and result block: offsets, codes, types.
package atr_pkg;

	// Register word offsets on the Avalon-MM slave (byte addresses).
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_TRIG   = 4'h4;
	localparam logic [3:0] OFF_RES_HI = 4'h8;
	localparam logic [3:0] OFF_RES_LO = 4'hC;

	// Control register field positions.
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_FORMAT_BIT = 1;
	localparam int CTRL_BUSY_BIT   = 2;

	// Reset values.
	localparam logic [3:0] TRIG_RESET = 4'h0;
	localparam logic [7:0] RES_RESET  = 8'h00;

	// Conversion time in clock cycles.
	localparam logic [5:0] CONV_CYCLES = 6'h20;

	// Trigger select codes.
	typedef enum logic [3:0] {
		TRIG_NONE  = 4'h0,
		TRIG_RSV1  = 4'h1,
		TRIG_RSV2  = 4'h2,
		TRIG_TMR0  = 4'h3,
		TRIG_TMR16 = 4'h4,
		TRIG_PRMAT = 4'h5,
		TRIG_CMP1  = 4'h6,
		TRIG_CMP2  = 4'h7,
		TRIG_LC1   = 4'h8,
		TRIG_LC2   = 4'h9
	} atr_trig_type;

	// Peripheral interrupt flags that can start a conversion.
	typedef struct packed {
		logic lc2;
		logic lc1;
		logic cmp2;
		logic cmp1;
		logic prmat;
		logic tmr16;
		logic tmr0;
	} atr_flags_type;

	// Converter sequencing states, Gray coded.
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CONV  = 2'b01,
		ST_STORE = 2'b11
	} atr_state_type;

endpackage

// ===== atr_block.sv
// Converter trigger select, conversion sequencing and result registers.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ns
module atr_block
	import atr_pkg::*;
(
	input  wire logic          MCLK,
	input  wire logic          SRST,
	input  wire logic [3:0]    AVS_ADDRESS,
	input  wire logic          AVS_READ,
	input  wire logic          AVS_WRITE,
	input  wire logic [31:0]   AVS_WRITEDATA,
	output logic [31:0]        AVS_READDATA,
	output logic               AVS_WAITREQUEST,
	input  wire atr_flags_type FLAGS,
	input  wire logic [9:0]    SAMPLE,
	output logic               BUSY
);

	////////////////////////////////////////////////////////////////////////
	// Flag inputs come from other peripherals on MCLK, so no synchroniser.
	atr_flags_type flags_prev;
	logic          sel_now;
	logic          sel_prev;
	logic          trig_edge;
	logic [3:0]    trig_sel;

	// Select one flag; reserved and unknown codes give a constant low.
	function automatic logic pick(input logic [3:0] code,
		input atr_flags_type f);
		unique case (code)
			TRIG_TMR0:  pick = f.tmr0;
			TRIG_TMR16: pick = f.tmr16;
			TRIG_PRMAT: pick = f.prmat;
			TRIG_CMP1:  pick = f.cmp1;
			TRIG_CMP2:  pick = f.cmp2;
			TRIG_LC1:   pick = f.lc1;
			TRIG_LC2:   pick = f.lc2;
			default:    pick = 1'b0;
		endcase
	endfunction

	// Both samples use the current select so a code change is no edge.
	always_comb begin
		sel_now   = pick(trig_sel, FLAGS);
		sel_prev  = pick(trig_sel, flags_prev);
		trig_edge = sel_now && !sel_prev;
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			flags_prev <= '0;
		end else begin
			flags_prev <= FLAGS;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus decode and conversion sequencer.
	atr_state_type state;
	atr_state_type next_state;
	logic [5:0]    count;
	logic [5:0]    next_count;
	logic          fmt_right;
	logic          next_fmt_right;
	logic [3:0]    next_trig_sel;
	logic [7:0]    res_hi;
	logic [7:0]    next_res_hi;
	logic [7:0]    res_lo;
	logic [7:0]    next_res_lo;
	logic [31:0]   next_readdata;
	logic          next_wait;
	logic          next_busy;
	logic          wr;
	logic          rd;
	logic          sw_start;

	// Waitrequest idles high and drops for one cycle, one edge after a
	// request is seen. Reads are decoded on that first edge so the data
	// stands with the low waitrequest; writes land on the edge where the
	// master sees waitrequest low, so a held write is applied just once.
	always_comb begin
		wr             = AVS_WRITE && !AVS_WAITREQUEST;
		rd             = AVS_READ && AVS_WAITREQUEST;
		sw_start       = wr && AVS_ADDRESS == OFF_CTRL
			&& AVS_WRITEDATA[CTRL_START_BIT];
		next_state     = state;
		next_count     = count;
		next_fmt_right = fmt_right;
		next_trig_sel  = trig_sel;
		next_res_hi    = res_hi;
		next_res_lo    = res_lo;
		next_readdata  = AVS_READDATA;
		next_wait      = !(AVS_READ || AVS_WRITE) || !AVS_WAITREQUEST;
		if (wr) begin
			unique case (AVS_ADDRESS)
				OFF_CTRL:   next_fmt_right = AVS_WRITEDATA[CTRL_FORMAT_BIT];
				OFF_TRIG:   next_trig_sel  = AVS_WRITEDATA[3:0];
				OFF_RES_HI: next_res_hi    = AVS_WRITEDATA[7:0];
				OFF_RES_LO: next_res_lo    = AVS_WRITEDATA[7:0];
				default:    ;
			endcase
		end
		if (rd) begin
			next_readdata = 32'h0000_0000;
			unique case (AVS_ADDRESS)
				OFF_CTRL: begin
					next_readdata[CTRL_FORMAT_BIT] = fmt_right;
					next_readdata[CTRL_BUSY_BIT]   = state != ST_IDLE;
				end
				OFF_TRIG:   next_readdata[3:0] = trig_sel;
				OFF_RES_HI: next_readdata[7:0] = res_hi;
				OFF_RES_LO: next_readdata[7:0] = res_lo;
				default:    ;
			endcase
		end
		// A trigger edge and a software start are the same request.
		unique case (state)
			ST_IDLE: if (trig_edge || sw_start) begin
				next_state = ST_CONV;
				next_count = CONV_CYCLES;
			end
			ST_CONV: begin
				next_count = count - 6'h01;
				if (count == 6'h01) next_state = ST_STORE;
			end
			ST_STORE: begin
				next_state = ST_IDLE;
				if (fmt_right) begin
					next_res_hi = {6'h00, SAMPLE[9:8]};
					next_res_lo = SAMPLE[7:0];
				end else begin
					next_res_hi = SAMPLE[9:2];
					next_res_lo = {SAMPLE[1:0], 6'h00};
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_busy = next_state != ST_IDLE;
	end

	// Results keep their value across reset; they are unknown at power-on.
	always_ff @(posedge MCLK) begin
		res_hi <= next_res_hi;
		res_lo <= next_res_lo;
		if (SRST) begin
			state           <= ST_IDLE;
			count           <= 6'h00;
			fmt_right       <= 1'b0;
			trig_sel        <= TRIG_RESET;
			AVS_READDATA    <= 32'h0000_0000;
			AVS_WAITREQUEST <= 1'b1;
			BUSY            <= 1'b0;
		end else begin
			state           <= next_state;
			count           <= next_count;
			fmt_right       <= next_fmt_right;
			trig_sel        <= next_trig_sel;
			AVS_READDATA    <= next_readdata;
			AVS_WAITREQUEST <= next_wait;
			BUSY            <= next_busy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks. All assertions are off while SRST is high; the result registers are
	// left out of reset on purpose, so their checks look only at stores.
	a_reserved_idle: assert property (@(posedge MCLK) disable iff (SRST)
		(trig_sel <= 4'h2 && !sw_start && state == ST_IDLE)
		|=> state == ST_IDLE)
		else $error("reserved trigger code started a conversion");
	a_level_no_start: assert property (@(posedge MCLK) disable iff (SRST)
		(state == ST_IDLE && sel_now && sel_prev && !sw_start)
		|=> state == ST_IDLE)
		else $error("held trigger level started a conversion");
	a_edge_starts: assert property (@(posedge MCLK) disable iff (SRST)
		(state == ST_IDLE && trig_edge) |=> state == ST_CONV && BUSY)
		else $error("trigger edge did not start a conversion");
	a_flag_set_start: assert property (@(posedge MCLK) disable iff (SRST)
		(state == ST_IDLE && trig_sel == TRIG_TMR16
		&& FLAGS.tmr16 && !$past(FLAGS.tmr16)) |=> state == ST_CONV)
		else $error("timer flag set did not start a conversion");
	a_left_high: assert property (@(posedge MCLK) disable iff (SRST)
		(state == ST_STORE && !fmt_right) |=> res_hi == $past(SAMPLE[9:2]))
		else $error("left high result wrong");
	a_left_low: assert property (@(posedge MCLK) disable iff (SRST)
		(state == ST_STORE && !fmt_right)
		|=> res_lo == {$past(SAMPLE[1:0]), 6'h00})
		else $error("left low result wrong");
	a_conv_length: assert property (@(posedge MCLK) disable iff (SRST)
		(state == ST_IDLE && next_state == ST_CONV)
		|=> state == ST_CONV [*8])
		else $error("conversion ended early");
	a_cmp2_select: assert property (@(posedge MCLK) disable iff (SRST)
		trig_sel == TRIG_CMP2 |-> sel_now == FLAGS.cmp2)
		else $error("code 0111 does not select comparator two");
	// Codes 1010 and up name no source, so they can never make an edge.
	a_upper_silent: assert property (@(posedge MCLK) disable iff (SRST)
		trig_sel >= 4'hA |-> !trig_edge)
		else $error("reserved upper code produced a trigger edge");
	// An edge while busy must not restart the count; it is dropped.
	a_busy_drops: assert property (@(posedge MCLK) disable iff (SRST)
		(state != ST_IDLE && trig_edge) |=> count != CONV_CYCLES)
		else $error("trigger edge restarted a running conversion");
	// A software start from idle behaves exactly like a trigger edge.
	a_sw_starts: assert property (@(posedge MCLK) disable iff (SRST)
		(state == ST_IDLE && sw_start) |=> state == ST_CONV && BUSY)
		else $error("software start did not begin a conversion");
	// Each request is answered by exactly one low cycle of waitrequest.
	a_bus_answer: assert property (@(posedge MCLK) disable iff (SRST)
		(AVS_WAITREQUEST && (AVS_READ || AVS_WRITE))
		|=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("bus answer was not a single low cycle");
	c_trig_conv: cover property (@(posedge MCLK) trig_edge ##1 BUSY);
	c_sw_conv: cover property (@(posedge MCLK) sw_start ##1 BUSY);
	c_store: cover property (@(posedge MCLK) state == ST_STORE);
	c_left_store: cover property (@(posedge MCLK)
		state == ST_STORE && !fmt_right);

endmodule // atr_block

// ===== atr_src_model.sv
// Peripheral event source model: interrupt flags and converter sample.
`timescale 1ns/1ns
module atr_src_model
	import atr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       busy,
	input  wire logic [6:0] evt,
	input  wire logic [9:0] val,
	output atr_flags_type   flags,
	output logic [9:0]      sample
);
	// Flags are levels that set one edge after a request. The converter
	// shows the inverse of its value while idle, so an early store fails.
	always @(posedge clk) begin
		flags  <= atr_flags_type'(evt);
		sample <= busy ? val : ~val;
	end
endmodule // atr_src_model

// ===== atr_tb.sv
// Self-checking testbench for the trigger and result block.
`timescale 1ns/1ns
module tb;
	import atr_pkg::*;
	logic          clk, srst, rd, wr, trig;
	logic [3:0]    addr;
	logic [31:0]   wdata, rdata, q, rnd;
	logic [6:0]    evt;
	logic [9:0]    val, smp;
	atr_flags_type flags;
	wire           busy;
	wire           wreq;
	int            failures, cmp_count, c;
	atr_block i_dut (.MCLK(clk), .SRST(srst), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .FLAGS(flags),
		.SAMPLE(smp), .BUSY(busy));
	atr_src_model i_src (.clk(clk), .busy(busy), .evt(evt), .val(val),
		.flags(flags), .sample(smp));
	////////////////////////////////////////////////////////////////////////
	// Random source, expectations and comparison.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Left-justified puts bits 9:2 high; right-justified puts 9:8 high.
	function automatic logic [15:0] exp_res(input logic f,
		input logic [9:0] s);
		return f ? {6'h00, s} : {s, 6'h00};
	endfunction
	// Flag bit that a trigger code selects; zero where it names no source.
	function automatic logic [6:0] src_bit(input int code);
		return (code >= 3 && code <= 9) ? 7'h01 << (code - 3) : 7'h00;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One Avalon-MM transfer; the request stands until waitrequest is
	// sampled low, and only the watchdog can end a wait that never ends.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wr    <= w;
		rd    <= !w;
		wdata <= d;
		do
			@(posedge clk);
		while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Clock, reset values and watchdog.
	initial begin
		clk   = 1'b0;
		srst  = 1'b1;
		rd    = 1'b0;
		wr    = 1'b0;
		addr  = 4'h0;
		wdata = 32'h0;
		evt   = 7'h00;
		val   = 10'h000;
		forever #2 clk = ~clk;
	end
	// The whole run needs about 1,000 cycles; this leaves ample margin.
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		summarize();
	end
	// Main sequence: registers, every trigger code, formats.
	initial begin
		failures  = 0;
		cmp_count = 0;
		rnd       = 32'h4712;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		// Reset value of the select and a read of an unmapped address.
		bus(1'b0, OFF_TRIG, 32'h0);
		chk(q, {28'h0, TRIG_RESET});
		bus(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		$display("Reset value tests done");
		// Unselected codes see every flag rise, which must start nothing.
		for (c = 0; c < 16; c++) begin
			rnd = lfsr(rnd);
			val <= rnd[9:0];
			trig = src_bit(c) != 7'h00;
			bus(1'b1, OFF_TRIG, 32'(c));
			evt <= trig ? src_bit(c) : 7'h7F;
			repeat (4) @(posedge clk);
			chk(32'(busy), 32'(trig));
			repeat (40) @(posedge clk);
			chk(32'(busy), 32'h0);
			evt <= 7'h00;
			repeat (3) @(posedge clk);
			chk(32'(busy), 32'h0);
			if (trig) begin
				bus(1'b0, OFF_RES_HI, 32'h0);
				chk(32'(q[7:0]), 32'(exp_res(1'b0, val) >> 8));
				bus(1'b0, OFF_RES_LO, 32'h0);
				chk(32'(q[7:0]), 32'(exp_res(1'b0, val) & 16'h00FF));
			end
			$display("Trigger code %0d done", c);
		end
		// Software start in right-justified form, then a direct write.
		bus(1'b1, OFF_TRIG, 32'h0);
		bus(1'b1, OFF_CTRL,
			32'h1 << CTRL_START_BIT | 32'h1 << CTRL_FORMAT_BIT);
		bus(1'b0, OFF_CTRL, 32'h0);
		chk(q, 32'h1 << CTRL_FORMAT_BIT | 32'h1 << CTRL_BUSY_BIT);
		repeat (40) @(posedge clk);
		bus(1'b0, OFF_RES_HI, 32'h0);
		chk(32'(q[7:0]), 32'(exp_res(1'b1, val) >> 8));
		bus(1'b0, OFF_RES_LO, 32'h0);
		chk(32'(q[7:0]), 32'(exp_res(1'b1, val) & 16'h00FF));
		bus(1'b1, OFF_CTRL, 32'h0);
		bus(1'b1, OFF_RES_HI, 32'hA5);
		bus(1'b0, OFF_RES_HI, 32'h0);
		chk(q, 32'hA5);
		$display("Format and register tests done");
		// A second edge that lands while a conversion runs is dropped.
		bus(1'b1, OFF_TRIG, 32'(TRIG_TMR0));
		evt <= 7'h01;
		repeat (10) @(posedge clk);
		evt <= 7'h00;
		repeat (2) @(posedge clk);
		evt <= 7'h01;
		repeat (30) @(posedge clk);
		chk(32'(busy), 32'h0);
		evt <= 7'h00;
		bus(1'b0, OFF_RES_HI, 32'h0);
		chk(32'(q[7:0]), 32'(exp_res(1'b0, val) >> 8));
		$display("Busy retrigger test done");
		// Reset in mid-conversion: control clears, the results are kept.
		bus(1'b1, OFF_CTRL, 32'h1 << CTRL_START_BIT);
		repeat (5) @(posedge clk);
		chk(32'(busy), 32'h1);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		chk(32'(busy), 32'h0);
		bus(1'b0, OFF_CTRL, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, OFF_RES_HI, 32'h0);
		chk(32'(q[7:0]), 32'(exp_res(1'b0, val) >> 8));
		$display("Mid-run reset test done");
		summarize();
	end
endmodule // tb
